// *** design/crs_card_reset.sv ***
// Card reset release sequencing, TS and ATR timeout supervision and supply-fault shutdown.
// Assumes etuTick, rxStartEdge and the register port come from logic on clk_sys;
// cardSupplyGood and vddLow come from analog circuits and are synchronised here.
//
// Implementation choice: the address-and-strobe port.
`include "crs_cfg.svh"

module crs_card_reset
  import crs_pkg::*;
#(
  parameter int NUM_IF = 2,
  parameter logic [2:0] FACTORY_THRESHOLD = 3'h0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Card UART and baud generator.
  input wire logic etuTick,
  input wire logic rxStartEdge,
  // Interface selection.
  input wire logic [$clog2(NUM_IF)-1:0] ifSelect,
  // Analog supervisors.
  input wire logic cardSupplyGood,
  input wire logic vddLow,
  output logic [2:0] faultThreshold,
  // Card side.
  output logic [NUM_IF-1:0] cardResetN,
  output logic [NUM_IF-1:0] cardDeactivate,
  output logic timeoutIrq
);

  // Register map, all byte wide:
  // Pin control: bit 7 holds the card in reset.
  // Protocol control: bit 0 arms ATR timing.
  // Byte control: bit 6 enables TS timing.
  // ATR limit: high byte first, low byte at the next address.
  // TS limit: one byte, the ETUs allowed before the TS start bit.
  // Release length: the ETUs between a release request and the release.
  // Status: timeout and fault flags, write one to clear; bit 3 shows the release.
  // Fault control: bit 6 override, bit 5 disable, bits 2 to 0 threshold code.
  // Other control bits are stored and read back; fault control keeps bits 7 and 4 at zero.
  // Register storage.
  logic [7:0] pinCtl;
  logic [7:0] protoCtl;
  logic [7:0] byteCtl;
  logic [7:0] atrLimitHigh;
  logic [7:0] atrLimitLow;
  logic [7:0] tsLimit;
  logic [7:0] relLength;
  logic [7:0] faultCtl;
  logic tsTimeout;
  logic atrTimeout;
  logic faultSeen;

  // Synchronisers.
  logic supplyGoodMeta;
  logic supplyGoodSync;
  logic vddLowMeta;
  logic vddLowSync;

  // Sequencer and counters.
  crs_state_t state;
  crs_state_t next_state;
  logic [7:0] delayCount;
  logic [8:0] tsCount;
  logic tsRun;
  logic [16:0] atrCount;
  logic atrRun;
  logic [$clog2(NUM_IF)-1:0] activeIf;

  // Compares an ETU count with its limit; the count must exceed the limit to trip.
  // Both sides carry one spare bit above the limit width, so a limit of all ones
  // can still be exceeded instead of the counter wrapping back to zero first.
  function automatic logic over_limit(input logic [16:0] count, input logic [16:0] limit);
    over_limit = count > limit;
  endfunction

  // Turns the latched slot index into a per-slot mask, gated by one condition.
  // The release and the deactivation both use it, so the two can never disagree
  // about which slot is meant.
  function automatic logic [NUM_IF-1:0] slot_mask(input logic [$clog2(NUM_IF)-1:0] slot, input logic on);
    slot_mask = '0;
    for (int i = 0; i < NUM_IF; i++) begin
      if (on && slot == i[$clog2(NUM_IF)-1:0]) begin
        slot_mask[i] = 1'b1;
      end
    end
  endfunction

  // Address decode. Full 16-bit compares: a partial decode would alias onto the
  // neighbouring card registers and let a stray write move a limit.
  wire selPin = regAddr == `CRS_OFS_PIN_CTL;
  wire selProto = regAddr == `CRS_OFS_PROTO_CTL;
  wire selByte = regAddr == `CRS_OFS_BYTE_CTL;
  wire selAtrHi = regAddr == `CRS_OFS_ATR_HI;
  wire selAtrLo = regAddr == `CRS_OFS_ATR_LO;
  wire selTs = regAddr == `CRS_OFS_TS_LIMIT;
  wire selRel = regAddr == `CRS_OFS_REL_LEN;
  wire selStatus = regAddr == `CRS_OFS_STATUS;
  wire selFault = regAddr == `CRS_OFS_FAULT_CTL;

  // Control fields. The ATR limit is rebuilt from its two bytes every cycle, so
  // firmware should write both bytes before arming ATR timing.
  wire resetHold = pinCtl[`CRS_BIT_RESET_HOLD];
  wire atrMode = protoCtl[`CRS_BIT_ATR_MODE];
  wire tsDetect = byteCtl[`CRS_BIT_TS_DETECT];
  wire thresholdOverride = faultCtl[`CRS_BIT_OVERRIDE];
  wire faultDisable = faultCtl[`CRS_BIT_FAULT_DIS];
  wire [2:0] thresholdField = faultCtl[`CRS_THR_HI:`CRS_THR_LO];
  wire [15:0] atrLimit = {atrLimitHigh, atrLimitLow};
  wire lenIsZero = relLength == `CRS_RST_ZERO;
  wire delayDone = delayCount == `CRS_RST_ZERO;

  // Supply fault only counts while detection is enabled and the card is powered.
  // While OFF there is no card to protect, and in FAULT the shutdown is already
  // latched; leaving both out keeps the status flag from retriggering.
  wire faultEvent = vddLowSync && !faultDisable && state != CRS_FAULT && state != CRS_OFF;

  // Timing conventions: every count advances only on an ETU tick, never on raw
  // clk_sys cycles, so the limits stay in ETUs whatever the card clock divider
  // is set to. A limit trips on the tick that finds the count already above it.
  // Counter events; only the two trips are paced by the ETU tick.
  wire releasePulse = state != CRS_RELEASED && next_state == CRS_RELEASED;
  wire tsStop = tsRun && rxStartEdge;
  wire tsTrip = tsRun && etuTick && over_limit({8'h00, tsCount}, {9'h000, tsLimit});
  wire atrStart = atrMode && !atrRun && rxStartEdge && atrCount == 17'h00000;
  wire atrTrip = atrRun && etuTick && over_limit(atrCount, {1'b0, atrLimit});

  // Status write-one-to-clear strobes.
  wire statusWr = regWr && selStatus;
  wire clrTs = statusWr && regWrData[`CRS_ST_TS_TO];
  wire clrAtr = statusWr && regWrData[`CRS_ST_ATR_TO];
  wire clrFault = statusWr && regWrData[`CRS_ST_FAULT];

  // Next values of the sticky flags and outputs. A new event wins over a clear in
  // the same cycle, so a timeout that lands on the clearing write is never lost.
  wire next_tsTimeout = tsTrip || (tsTimeout && !clrTs);
  wire next_atrTimeout = atrTrip || (atrTimeout && !clrAtr);
  wire next_faultSeen = faultEvent || (faultSeen && !clrFault);
  wire next_timeoutIrq = next_tsTimeout || next_atrTimeout;
  wire [NUM_IF-1:0] next_cardResetN = slot_mask(activeIf, next_state == CRS_RELEASED);
  wire [NUM_IF-1:0] next_cardDeactivate = slot_mask(activeIf, next_state == CRS_FAULT);

  // Read data mux; unmapped addresses read zero.
  wire [7:0] statusByte = {4'h0, state == CRS_RELEASED, faultSeen, atrTimeout, tsTimeout};
  wire [7:0] readMux =
    selPin ? pinCtl :
    selProto ? protoCtl :
    selByte ? byteCtl :
    selAtrHi ? atrLimitHigh :
    selAtrLo ? atrLimitLow :
    selTs ? tsLimit :
    selRel ? relLength :
    selStatus ? statusByte :
    selFault ? faultCtl : `CRS_RST_ZERO;

  // Threshold handed to the comparator: code 0 is 2.3 V, each step adds 0.1 V.
  // The code is forwarded every cycle rather than sampled at power-up, so firmware
  // should change it only once the card is up, or the comparator reference may
  // step while the card is being powered.
  wire [2:0] next_threshold = thresholdOverride ? thresholdField : FACTORY_THRESHOLD;

  // Two flip-flop synchronisers for the analog levels.
  // Both levels come from comparators with no relation to clk_sys. Only the second
  // stage is read, and the two cycles of latency are far below one ETU.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      supplyGoodMeta <= 1'b0;
      supplyGoodSync <= 1'b0;
      vddLowMeta <= 1'b0;
      vddLowSync <= 1'b0;
    end else begin
      supplyGoodMeta <= cardSupplyGood;
      supplyGoodSync <= supplyGoodMeta;
      vddLowMeta <= vddLow;
      vddLowSync <= vddLowMeta;
    end
  end

  // Register writes; reserved fault-control bits are never stored.
  // Hardware never writes these registers, so firmware owns them completely and
  // no write can collide with an internal update.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinCtl <= `CRS_RST_ZERO;
      protoCtl <= `CRS_RST_ZERO;
      byteCtl <= `CRS_RST_ZERO;
      atrLimitHigh <= `CRS_RST_ZERO;
      atrLimitLow <= `CRS_RST_ZERO;
      tsLimit <= `CRS_RST_ZERO;
      relLength <= `CRS_RST_REL_LEN;
      faultCtl <= `CRS_RST_ZERO;
    end else if (regWr) begin
      if (selPin) pinCtl <= regWrData;
      if (selProto) protoCtl <= regWrData;
      if (selByte) byteCtl <= regWrData;
      if (selAtrHi) atrLimitHigh <= regWrData;
      if (selAtrLo) atrLimitLow <= regWrData;
      if (selTs) tsLimit <= regWrData;
      if (selRel) relLength <= regWrData;
      if (selFault) faultCtl <= regWrData & `CRS_FAULT_CTL_MASK;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  // Returning zero outside that cycle lets the read buses of several slaves be
  // ORed together without a separate output enable.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= `CRS_RST_ZERO;
    end else begin
      regRdData <= regRd ? readMux : `CRS_RST_ZERO;
    end
  end

  // Sticky status flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tsTimeout <= 1'b0;
      atrTimeout <= 1'b0;
      faultSeen <= 1'b0;
    end else begin
      tsTimeout <= next_tsTimeout;
      atrTimeout <= next_atrTimeout;
      faultSeen <= next_faultSeen;
    end
  end

  // Sequencer states:
  // OFF: the card supply is not yet good; reset is low and the slot may change.
  // HOLD: the supply is good but firmware holds reset until the hold bit clears.
  // DELAY: the release length is counted down in ETU ticks before the release.
  // RELEASED: card reset is high on the latched slot; TS and ATR timing may run.
  // FAULT: low core supply was seen; the slot stays deactivated until power drops.
  // Hold set in DELAY or RELEASED goes back to HOLD, and clearing it reloads the
  // full delay, so a firmware retry always gets the whole release length again.
  // Sequencer next state. A fault beats the hold bit and any running delay, and
  // losing card power always drops back to the off state.
  always_comb begin
    next_state = state;
    unique case (state)
      CRS_OFF: begin
        if (supplyGoodSync && !resetHold) begin
          next_state = lenIsZero ? CRS_RELEASED : CRS_DELAY;
        end else if (supplyGoodSync) begin
          next_state = CRS_HOLD;
        end
      end
      CRS_HOLD: begin
        if (!resetHold) next_state = lenIsZero ? CRS_RELEASED : CRS_DELAY;
      end
      CRS_DELAY: begin
        if (resetHold) next_state = CRS_HOLD;
        else if (etuTick && delayCount == 8'h01) next_state = CRS_RELEASED;
      end
      CRS_RELEASED: begin
        if (resetHold) next_state = CRS_HOLD;
      end
      CRS_FAULT: begin
        next_state = CRS_FAULT;
      end
    endcase
    if (faultEvent) next_state = CRS_FAULT;
    if (!supplyGoodSync) next_state = CRS_OFF;
  end

  // State register and release delay counter, loaded whenever the delay begins.
  // The length is sampled on entry to DELAY, so a length written during the count
  // only applies to the next release.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= CRS_OFF;
      delayCount <= `CRS_RST_ZERO;
    end else begin
      state <= next_state;
      if (next_state == CRS_DELAY && state != CRS_DELAY) delayCount <= relLength;
      else if (state == CRS_DELAY && etuTick && !delayDone) delayCount <= delayCount - 8'h01;
    end
  end

  // The interface is latched while the card is off, so a select change during a
  // session cannot move a released reset to another slot.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activeIf <= '0;
    end else if (state == CRS_OFF) begin
      activeIf <= ifSelect;
    end
  end

  // TS timer: starts at reset release when TS detection is on, stops at the first
  // start bit or on a trip. The trip stops it, so the spare top bit never wraps.
  // With TS detection off the timer never starts and the TS limit is ignored.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tsRun <= 1'b0;
      tsCount <= 9'h000;
    end else if (releasePulse) begin
      tsRun <= tsDetect;
      tsCount <= 9'h000;
    end else if (tsStop || tsTrip || state != CRS_RELEASED) begin
      tsRun <= 1'b0;
    end else if (tsRun && etuTick) begin
      tsCount <= tsCount + 9'h001;
    end
  end

  // ATR timer: armed by ATR mode, started by the first start bit, cleared when
  // the mode is cleared so the next ATR starts fresh.
  // A new ATR therefore needs the mode bit cleared and set again.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      atrRun <= 1'b0;
      atrCount <= 17'h00000;
    end else if (!atrMode) begin
      atrRun <= 1'b0;
      atrCount <= 17'h00000;
    end else if (atrStart) begin
      atrRun <= 1'b1;
    end else if (atrTrip) begin
      atrRun <= 1'b0;
    end else if (atrRun && etuTick) begin
      atrCount <= atrCount + 17'h00001;
    end
  end

  // Registered outputs. Reset is low everywhere except the selected slot once
  // released; deactivation is held until card power goes away.
  // Outputs load from next values so the pins change on the same edge as the
  // state, with no decode glitches toward the pads.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cardResetN <= '0;
      cardDeactivate <= '0;
      timeoutIrq <= 1'b0;
      faultThreshold <= FACTORY_THRESHOLD;
    end else begin
      cardResetN <= next_cardResetN;
      cardDeactivate <= next_cardDeactivate;
      timeoutIrq <= next_timeoutIrq;
      faultThreshold <= next_threshold;
    end
  end

endmodule // crs_card_reset

// *** design/crs_cfg.svh ***
// Register offsets, field positions and reset values for the card reset sequencer.
// Assumes an 8-bit register port with a 16-bit byte address.
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// Register offsets.
`define CRS_OFS_PIN_CTL 16'hfe0a
`define CRS_OFS_PROTO_CTL 16'hfe0d
`define CRS_OFS_BYTE_CTL 16'hfe12
`define CRS_OFS_ATR_HI 16'hfe1f
`define CRS_OFS_ATR_LO 16'hfe20
`define CRS_OFS_TS_LIMIT 16'hfe21
`define CRS_OFS_REL_LEN 16'hfe22
`define CRS_OFS_STATUS 16'hfe23
`define CRS_OFS_FAULT_CTL 16'hffd4

// Reset values.
`define CRS_RST_ZERO 8'h00
`define CRS_RST_REL_LEN 8'h70

// Field positions.
`define CRS_BIT_RESET_HOLD 7
`define CRS_BIT_ATR_MODE 0
`define CRS_BIT_TS_DETECT 6
`define CRS_BIT_OVERRIDE 6
`define CRS_BIT_FAULT_DIS 5
`define CRS_THR_HI 2
`define CRS_THR_LO 0
`define CRS_FAULT_CTL_MASK 8'h6f

// Status bits, write one to clear the sticky ones.
`define CRS_ST_TS_TO 0
`define CRS_ST_ATR_TO 1
`define CRS_ST_FAULT 2
`define CRS_ST_RELEASED 3

`endif

// *** design/crs_pkg.sv ***
// Types shared by the card reset sequencer.
// Assumes crs_cfg.svh holds the numeric constants.
package crs_pkg;

  // Card reset sequencing states, one-hot.
  typedef enum logic [4:0] {
    CRS_OFF = 5'h01,
    CRS_HOLD = 5'h02,
    CRS_DELAY = 5'h04,
    CRS_RELEASED = 5'h08,
    CRS_FAULT = 5'h10
  } crs_state_t;

endpackage

// *** verif/crs_card_model.sv ***
// Stand-in for the card in the slot: answers a reset release with a start bit.
// Assumes etuTick and rxStartEdge are one-cycle pulses on clk_sys.
module crs_card_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Card side.
  input wire logic [1:0] cardResetN,
  input wire logic etuTick,
  input wire logic [31:0] tsGap,
  output logic rxStartEdge
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic armed;
  // The card stays mute while held in reset, then starts TS after tsGap ETUs.
  always_ff @(posedge clk_sys) begin
    if (rst || cardResetN == 2'h0) begin
      cnt <= 0;
      armed <= 1'b1;
      rxStartEdge <= 1'b0;
    end else begin
      rxStartEdge <= armed && cnt == tsGap;
      if (armed && cnt == tsGap) armed <= 1'b0;
      else if (etuTick) cnt <= cnt + 1;
    end
  end
endmodule // crs_card_model

// *** verif/crs_card_reset_properties.sv ***
// Port-level checks of the card reset sequencer.
// Assumes one clk_sys domain with synchronous active-high rst.
module crs_card_reset_properties #(
  parameter int NUM_IF = 2,
  parameter logic [2:0] FACTORY_THRESHOLD = 3'h0
) (
  // Clock, reset and register port.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Timing, supervisors and card side.
  input wire logic etuTick,
  input wire logic vddLow,
  input wire logic cardSupplyGood,
  input wire logic [2:0] faultThreshold,
  input wire logic [NUM_IF-1:0] cardResetN,
  input wire logic [NUM_IF-1:0] cardDeactivate,
  input wire logic timeoutIrq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic faultDis;
  logic [2:0] thrExp;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadows of the fault control register, which the ports do not show.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultDis <= 1'b0;
      thrExp <= FACTORY_THRESHOLD;
    end else if (regWr && regAddr == 16'hffd4) begin
      faultDis <= regWrData[5];
      thrExp <= regWrData[6] ? regWrData[2:0] : FACTORY_THRESHOLD;
    end
  end
  a_deact_reset: assert property ((cardDeactivate & cardResetN) == '0)
    else $error("deactivated slot has reset released");
  a_one_slot: assert property ($onehot0(cardResetN))
    else $error("more than one slot released");
  a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");
  a_thr_select: assert property (regWr && regAddr == 16'hffd4 |-> ##2 faultThreshold == $past(thrExp))
    else $error("threshold code mismatch");
  a_hold_assert: assert property (regWr && regAddr == 16'hfe0a && regWrData[7] |-> ##[1:3] cardResetN == '0)
    else $error("hold did not assert reset");
  a_fault_deact: assert property (vddLow && !faultDis && cardResetN != '0 |-> ##[1:5] cardDeactivate != '0)
    else $error("low supply did not deactivate");
  a_fault_off: assert property (faultDis && cardDeactivate == '0 |=> cardDeactivate == '0)
    else $error("deactivated while fault disabled");
  a_irq_tick: assert property ($rose(timeoutIrq) |-> $past(etuTick) || $past(etuTick, 2))
    else $error("timeout not on an ETU tick");
  a_fault_sticky: assert property (cardDeactivate != '0 && cardSupplyGood |=> cardDeactivate == $past(cardDeactivate))
    else $error("deactivation left early");
endmodule // crs_card_reset_properties

bind crs_card_reset crs_card_reset_properties #(.NUM_IF(NUM_IF), .FACTORY_THRESHOLD(FACTORY_THRESHOLD)) u_props (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .etuTick(etuTick), .vddLow(vddLow), .cardSupplyGood(cardSupplyGood),
  .faultThreshold(faultThreshold), .cardResetN(cardResetN), .cardDeactivate(cardDeactivate),
  .timeoutIrq(timeoutIrq));

// *** verif/testbench.sv ***
// Self-checking bench for the card reset sequencer.
// Assumes the design, the card model and the bound checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, rst = 1, regWr = 0, regRd = 0, etuTick = 0, linkClk = 0, linkQ = 0;
  logic cardSupplyGood = 0, vddLow = 0, rxStartEdge, timeoutIrq;
  logic [0:0] ifSelect = 0;
  logic [15:0] regAddr = 0;
  logic [7:0] regWrData = 0, regRdData;
  logic [2:0] faultThreshold;
  logic [1:0] cardResetN, cardDeactivate;
  int num_errors = 0, cmp_count = 0, cyc = 0, tsGap = 1;
  // System clock, and a 160 ns link clock whose rises become ETU ticks.
  always #5 clk_sys = ~clk_sys;
  always #80 linkClk = ~linkClk;
  always @(posedge clk_sys) begin
    linkQ <= linkClk;
    etuTick <= linkClk & ~linkQ;
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out;
    end
  end
  crs_card_reset #(.NUM_IF(2)) u_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .etuTick(etuTick),
    .rxStartEdge(rxStartEdge), .ifSelect(ifSelect), .cardSupplyGood(cardSupplyGood), .vddLow(vddLow),
    .faultThreshold(faultThreshold), .cardResetN(cardResetN), .cardDeactivate(cardDeactivate),
    .timeoutIrq(timeoutIrq));
  crs_card_model u_card (.clk_sys(clk_sys), .rst(rst), .cardResetN(cardResetN), .etuTick(etuTick),
    .tsGap(tsGap), .rxStartEdge(rxStartEdge));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic etus(input int n);
    repeat (n) @(posedge etuTick);
    tk(2);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd <= 1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 0;
    #1 chk(regRdData, exp);
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence; each step leans on the state left by the one before.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    rd(16'hfe21, 8'h00);
    rd(16'hfe22, 8'h70);
    rd(16'hfe1f, 8'h00);
    rd(16'hffd4, 8'h00);
    rd(16'hfe30, 8'h00);
    wr(16'hfe1f, 8'h12);
    wr(16'hfe20, 8'h34);
    rd(16'hfe1f, 8'h12);
    rd(16'hfe20, 8'h34);
    wr(16'hfe22, 8'h00);
    wr(16'hfe21, 8'h02);
    wr(16'hfe12, 8'h40);
    @(posedge clk_sys);
    cardSupplyGood <= 1;
    tk(5);
    chk(cardResetN, 8'h01);
    tk(160);
    chk(timeoutIrq, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(16'hffd4, 8'h40 | i[7:0]);
      tk(2);
      chk(faultThreshold, i[7:0]);
    end
    wr(16'hffd4, 8'hff);
    rd(16'hffd4, 8'h6f);
    wr(16'hffd4, 8'h05);
    tk(2);
    chk(faultThreshold, 8'h00);
    wr(16'hfe0a, 8'h80);
    tk(3);
    chk(cardResetN, 8'h00);
    wr(16'hfe22, 8'h03);
    tsGap <= 5;
    etus(1);
    wr(16'hfe0a, 8'h00);
    etus(2);
    chk(cardResetN, 8'h00);
    etus(1);
    chk(cardResetN, 8'h01);
    tk(128);
    chk(timeoutIrq, 8'h01);
    rd(16'hfe23, 8'h09);
    wr(16'hfe23, 8'h01);
    tk(2);
    chk(timeoutIrq, 8'h00);
    wr(16'hfe1f, 8'h00);
    wr(16'hfe20, 8'h02);
    wr(16'hfe12, 8'h00);
    wr(16'hfe0d, 8'h01);
    wr(16'hfe0a, 8'h80);
    etus(1);
    wr(16'hfe0a, 8'h00);
    tk(224);
    chk(timeoutIrq, 8'h01);
    rd(16'hfe23, 8'h0a);
    wr(16'hfe0d, 8'h00);
    wr(16'hfe23, 8'h02);
    tk(2);
    chk(timeoutIrq, 8'h00);
    @(posedge clk_sys);
    cardSupplyGood <= 0;
    ifSelect <= 1;
    wr(16'hfe0a, 8'h80);
    @(posedge clk_sys);
    cardSupplyGood <= 1;
    tk(80);
    chk(cardResetN, 8'h00);
    etus(1);
    wr(16'hfe0a, 8'h00);
    etus(3);
    chk(cardResetN, 8'h02);
    wr(16'hffd4, 8'h20);
    vddLow <= 1;
    tk(10);
    chk(cardDeactivate, 8'h00);
    wr(16'hffd4, 8'h00);
    tk(6);
    chk(cardDeactivate, 8'h02);
    chk(cardResetN, 8'h00);
    rd(16'hfe23, 8'h04);
    @(posedge clk_sys);
    vddLow <= 0;
    cardSupplyGood <= 0;
    tk(5);
    chk(cardDeactivate, 8'h00);
    close_out;
  end
endmodule // testbench
